// ---- pkg/ssb_pkg.sv ----
// Shared constants and types of the servo stop and brake sequencer
package ssb_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int unsigned SPEED_W = 14;
    localparam int unsigned SDLY_W  = 6;
    localparam int unsigned RDLY_W  = 7;
    localparam int unsigned MODE_W  = 2;
    localparam int unsigned ROUTE_W = 2;
    localparam int unsigned NOUT    = 3;
    localparam int unsigned DIV_W   = 21;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_KHZ         = 125000;
    localparam int unsigned TICK_MS         = 10;
    localparam int unsigned TICK_CYCLES_DEF = TICK_MS * CLK_KHZ;

    // ****************************************
    // Settings encodings
    // ****************************************
    localparam logic [MODE_W-1:0]  MODE_DB_HOLD = 2'h0;
    localparam logic [MODE_W-1:0]  MODE_DB_FREE = 2'h1;
    localparam logic [MODE_W-1:0]  MODE_COAST   = 2'h2;
    localparam logic [ROUTE_W-1:0] ROUTE_NONE   = 2'h0;
    localparam logic               SEQ_BYPASS   = 1'h1;
    localparam logic               ENC_INCR     = 1'h1;

    // Speed below which the motor counts as stopped (r/min)
    localparam logic [SPEED_W-1:0] LOW_SPEED_RPM = 14'h000A;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [NOUT-1:0]   OUT_RESET   = 3'h0;
    localparam logic [1:0]        PWR_RESET   = 2'h0;
    localparam logic [RDLY_W-1:0] CNT_RESET   = 7'h00;
    localparam logic [DIV_W-1:0]  DIV_RESET   = 21'h000000;

    // ****************************************
    // Sequencer states
    // ****************************************
    typedef enum logic [3:0] {
        ST_OFF   = 4'h1,
        ST_RUN   = 4'h2,
        ST_HOLD  = 4'h4,
        ST_COAST = 4'h8
    } ssb_state_t;

endpackage : ssb_pkg

// ---- pkg/ssb_timer_if.sv ----
// Carrier between the sequencer and its 10 ms delay timer
`timescale 1ns/1ns
interface ssb_timer_if;
    logic                        start;
    logic [ssb_pkg::RDLY_W-1:0]  load;
    logic                        expired;

    modport ctl (output start, output load, input expired);
    modport tmr (input start, input load, output expired);
endinterface : ssb_timer_if

// ---- hw/ssb_tick_timer.sv ----
// 10 ms tick divider and delay down-counter
`timescale 1ns/1ns
module ssb_tick_timer #(
    parameter int unsigned TICK_CYCLES = ssb_pkg::TICK_CYCLES_DEF
) (
    input  wire logic mclk_i,
    input  wire logic reset_i,
    ssb_timer_if.tmr  bus
);
    import ssb_pkg::*;

    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

    logic [DIV_W-1:0]  div_reg;
    logic [RDLY_W-1:0] cnt_reg;
    logic              armed_reg;
    wire               tick_w = (div_reg == DIV_LAST);

    // ****************************************
    // Divider restarts with each delay
    // ****************************************
    // Restarting the divider keeps the first tick a full 10 ms away
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            div_reg   <= DIV_RESET;
            cnt_reg   <= CNT_RESET;
            armed_reg <= 1'b0;
        end else if (bus.start) begin
            div_reg   <= DIV_RESET;
            cnt_reg   <= bus.load;
            armed_reg <= 1'b1;
        end else begin
            div_reg <= tick_w ? DIV_RESET : div_reg + 1'b1;
            if (tick_w && cnt_reg != CNT_RESET) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end

    assign bus.expired = armed_reg && !bus.start && (cnt_reg == CNT_RESET);

endmodule : ssb_tick_timer

// ---- hw/ssb_seq.sv ----
// Servo stop-mode and holding-brake sequencer
`timescale 1ns/1ns
module ssb_seq #(
    parameter int unsigned TICK_CYCLES = ssb_pkg::TICK_CYCLES_DEF
) (
    input  wire logic                         mclk_i,
    input  wire logic                         reset_i,
    input  wire logic                         servo_on_command_i,
    input  wire logic                         servo_off_command_i,
    input  wire logic                         servo_alarm_i,
    input  wire logic                         main_power_off_i,
    input  wire logic                         ctrl_power_off_i,
    input  wire logic [ssb_pkg::SPEED_W-1:0]  motor_speed_i,
    input  wire logic [ssb_pkg::SPEED_W-1:0]  max_speed_i,
    input  wire logic [ssb_pkg::MODE_W-1:0]   stop_mode_select_i,
    input  wire logic                         brake_sequence_enable_i,
    input  wire logic [ssb_pkg::SDLY_W-1:0]   stopped_brake_delay_i,
    input  wire logic [ssb_pkg::SPEED_W-1:0]  brake_release_speed_i,
    input  wire logic [ssb_pkg::RDLY_W-1:0]   running_brake_delay_i,
    input  wire logic [ssb_pkg::ROUTE_W-1:0]  brake_output_route_i,
    input  wire logic [ssb_pkg::NOUT-1:0]     other_out_i,
    input  wire logic                         encoder_abs_mode_i,
    output logic                              motor_drive_o,
    output logic                              dynamic_brake_o,
    output logic                              brake_interlock_out_o,
    output logic [ssb_pkg::NOUT-1:0]          out_circuit_o,
    output logic                              encoder_incremental_o,
    output logic                              abs_detect_enable_o
);
    import ssb_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [SPEED_W-1:0] min_speed(input logic [SPEED_W-1:0] a,
                                                     input logic [SPEED_W-1:0] b);
        min_speed = (a < b) ? a : b;
    endfunction : min_speed

    function automatic logic [NOUT-1:0] route_mask(input logic [ROUTE_W-1:0] r);
        logic [NOUT-1:0] m;
        m = '0;
        if (r != ROUTE_NONE) begin
            m[r - 1'b1] = 1'b1;
        end
        route_mask = m;
    endfunction : route_mask

    // ****************************************
    // Power pin synchronisers
    // ****************************************
    logic [1:0] pwr_s1_reg;
    logic [1:0] pwr_s2_reg;
    logic [1:0] pwr_s3_reg;
    logic [1:0] pwr_filt_reg;
    logic [1:0] pwr_filt_next;

    // A level counts only once two stages agree, which rejects one-cycle glitches
    assign pwr_filt_next = (pwr_s2_reg & pwr_s3_reg) | (pwr_filt_reg & (pwr_s2_reg | pwr_s3_reg));

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pwr_s1_reg   <= PWR_RESET;
            pwr_s2_reg   <= PWR_RESET;
            pwr_s3_reg   <= PWR_RESET;
            pwr_filt_reg <= PWR_RESET;
        end else begin
            pwr_s1_reg   <= {ctrl_power_off_i, main_power_off_i};
            pwr_s2_reg   <= pwr_s1_reg;
            pwr_s3_reg   <= pwr_s2_reg;
            pwr_filt_reg <= pwr_filt_next;
        end
    end

    wire power_off_w = |pwr_filt_reg;
    wire both_off_w  = &pwr_filt_reg;
    wire power_on_w  = pwr_filt_reg[1] && !pwr_filt_next[1];

    // ****************************************
    // Decoding
    // ****************************************
    wire seq_on_w   = (brake_sequence_enable_i != SEQ_BYPASS);
    wire stopped_w  = (motor_speed_i < LOW_SPEED_RPM);
    wire [SPEED_W-1:0] thresh_w = min_speed(brake_release_speed_i, max_speed_i);
    wire below_w    = (motor_speed_i < thresh_w);
    wire off_evt_w  = servo_off_command_i || servo_alarm_i || power_off_w;
    wire on_req_w   = servo_on_command_i && !off_evt_w;

    // ****************************************
    // Sequencer
    // ****************************************
    ssb_state_t state_reg;
    ssb_state_t state_next;
    logic       start_t;
    logic [RDLY_W-1:0] load_t;
    ssb_timer_if tif ();

    always_comb begin
        state_next = state_reg;
        start_t    = 1'b0;
        load_t     = running_brake_delay_i;
        unique case (state_reg)
            ST_OFF: begin
                if (on_req_w) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (off_evt_w) begin
                    if (!seq_on_w || power_off_w) begin
                        state_next = ST_OFF;
                    end else if (!stopped_w) begin
                        state_next = ST_COAST;
                        start_t    = 1'b1;
                    end else if (servo_alarm_i) begin
                        state_next = ST_OFF;
                    end else if (stopped_brake_delay_i == '0) begin
                        state_next = ST_OFF;
                    end else begin
                        state_next = ST_HOLD;
                        start_t    = 1'b1;
                        load_t     = RDLY_W'(stopped_brake_delay_i);
                    end
                end
            end
            ST_HOLD: begin
                if (servo_alarm_i || power_off_w) begin
                    state_next = ST_OFF;
                end else if (tif.expired) begin
                    state_next = ST_OFF;
                end
            end
            ST_COAST: begin
                if (below_w || tif.expired || power_off_w) begin
                    state_next = ST_OFF;
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
    end

    assign tif.start = start_t;
    assign tif.load  = load_t;

    ssb_tick_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .bus     (tif)
    );

    // ****************************************
    // Output decode
    // ****************************************
    logic low_reg;
    wire  leave_w     = (state_reg == ST_RUN) && (state_next != ST_RUN);
    wire  low_next    = leave_w ? stopped_w : low_reg;
    wire  drive_next  = (state_next == ST_RUN) || (state_next == ST_HOLD);
    wire  ilock_next  = (state_next == ST_RUN) || (state_next == ST_COAST);
    wire  db_mode_w   = (stop_mode_select_i == MODE_DB_HOLD) ? !low_next :
                        (stop_mode_select_i == MODE_DB_FREE) ? !stopped_w : 1'b0;
    wire  db_next     = !drive_next && (db_mode_w || both_off_w);
    wire [NOUT-1:0] out_next = other_out_i | (route_mask(brake_output_route_i) & {NOUT{ilock_next}});

    // ****************************************
    // Encoder mode latch
    // ****************************************
    logic load_pend_reg;
    wire  enc_load_w = load_pend_reg || power_on_w;

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_reg             <= ST_OFF;
            low_reg               <= 1'b0;
            motor_drive_o         <= 1'b0;
            dynamic_brake_o       <= 1'b0;
            brake_interlock_out_o <= 1'b0;
            out_circuit_o         <= OUT_RESET;
        end else begin
            state_reg             <= state_next;
            low_reg               <= low_next;
            motor_drive_o         <= drive_next;
            dynamic_brake_o       <= db_next;
            brake_interlock_out_o <= ilock_next;
            out_circuit_o         <= out_next;
        end
    end

    // Reset stands for a power cycle, so the mode is sampled once after it
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            load_pend_reg         <= 1'b1;
            encoder_incremental_o <= 1'b0;
            abs_detect_enable_o   <= 1'b0;
        end else begin
            load_pend_reg <= 1'b0;
            if (enc_load_w) begin
                encoder_incremental_o <= (encoder_abs_mode_i == ENC_INCR);
                abs_detect_enable_o   <= (encoder_abs_mode_i != ENC_INCR);
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    property p_alarm_cut;
        (state_reg == ST_RUN || state_reg == ST_HOLD) && servo_alarm_i |=> !motor_drive_o;
    endproperty
    a_alarm_cut: assert property (p_alarm_cut) else $error("alarm did not cut drive");

    property p_zero_delay;
        state_reg == ST_RUN && servo_off_command_i && !servo_alarm_i && !power_off_w
            && seq_on_w && stopped_w && stopped_brake_delay_i == '0
        |=> !motor_drive_o && !brake_interlock_out_o;
    endproperty
    a_zero_delay: assert property (p_zero_delay) else $error("zero delay not simultaneous");

    property p_hold_outputs;
        state_reg == ST_HOLD |-> motor_drive_o && !brake_interlock_out_o;
    endproperty
    a_hold_outputs: assert property (p_hold_outputs) else $error("hold outputs wrong");

    property p_moving_off;
        state_reg == ST_RUN && off_evt_w && !power_off_w && seq_on_w && !stopped_w
        |=> !motor_drive_o && brake_interlock_out_o;
    endproperty
    a_moving_off: assert property (p_moving_off) else $error("moving servo-off wrong");

    property p_speed_release;
        state_reg == ST_COAST && below_w |=> !brake_interlock_out_o;
    endproperty
    a_speed_release: assert property (p_speed_release) else $error("speed release missed");

    property p_time_release;
        state_reg == ST_COAST && tif.expired |=> !brake_interlock_out_o;
    endproperty
    a_time_release: assert property (p_time_release) else $error("timeout release missed");

    property p_bypass;
        state_reg == ST_RUN && off_evt_w && !seq_on_w
        |=> !motor_drive_o && !brake_interlock_out_o;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not immediate");

    property p_coast_no_db;
        stop_mode_select_i == MODE_COAST && !both_off_w |=> !dynamic_brake_o;
    endproperty
    a_coast_no_db: assert property (p_coast_no_db) else $error("dynamic brake in coast");

    property p_or_route;
        1'b1 |=> (out_circuit_o & $past(other_out_i)) == $past(other_out_i);
    endproperty
    a_or_route: assert property (p_or_route) else $error("output OR lost");

    property p_enc_hold;
        !enc_load_w |=> $stable(encoder_incremental_o);
    endproperty
    a_enc_hold: assert property (p_enc_hold) else $error("encoder mode changed early");

    c_hold_path:  cover property (state_reg == ST_HOLD ##1 state_reg == ST_OFF);
    c_speed_path: cover property (state_reg == ST_COAST && below_w);
    c_time_path:  cover property (state_reg == ST_COAST && tif.expired && !below_w);
    c_both_off:   cover property (both_off_w && dynamic_brake_o);

endmodule : ssb_seq

// ---- verif/ssb_relay_model.sv ----
// Brake control relay model fed by the routed output circuits
`timescale 1ns/1ns
module ssb_relay_model (
    input  wire logic [ssb_pkg::NOUT-1:0]    out_circuit_i,
    input  wire logic [ssb_pkg::ROUTE_W-1:0] route_i,
    output logic                             brake_held_o
);
    import ssb_pkg::*;
    // ****************************************
    // Relay coil and spring brake
    // ****************************************
    logic coil;
    logic [ROUTE_W-1:0] idx;
    assign idx = route_i - 2'h1;
    // Coil sees only the circuit wired to it; other functions ORed there also pull it in
    assign coil = (route_i == ROUTE_NONE) ? 1'b0 : out_circuit_i[idx];
    // Spring brake holds unless the coil is energised
    assign brake_held_o = ~coil;
endmodule : ssb_relay_model

// ---- verif/test_servo_stop_brake_sequencer.sv ----
// Self-checking bench of the servo stop and brake sequencer
`timescale 1ns/1ns
module test_servo_stop_brake_sequencer;
    import ssb_pkg::*;
    // ****************************************
    // Rows and signals
    // ****************************************
    // Short tick keeps delay scenarios to a few hundred cycles
    localparam int unsigned TCK = 10;
    typedef struct packed {
        logic [MODE_W-1:0]  mode;
        logic [ROUTE_W-1:0] route;
        logic [NOUT-1:0]    other;
        logic [SPEED_W-1:0] spd;
        logic [SPEED_W-1:0] rel;
        logic [SPEED_W-1:0] mx;
        logic               db;
        logic               il;
        logic               db_end;
    } ssb_row_t;
    localparam ssb_row_t ROWS [5] = '{
        '{2'h0, 2'h1, 3'h0, 14'h01F4, 14'h0064, 14'h0BB8, 1'h1, 1'h1, 1'h1},
        '{2'h1, 2'h2, 3'h0, 14'h01F4, 14'h0064, 14'h0BB8, 1'h1, 1'h1, 1'h0},
        '{2'h2, 2'h3, 3'h1, 14'h01F4, 14'h0064, 14'h0BB8, 1'h0, 1'h1, 1'h0},
        '{2'h0, 2'h1, 3'h1, 14'h0096, 14'h0BB8, 14'h00C8, 1'h1, 1'h0, 1'h1},
        '{2'h3, 2'h0, 3'h2, 14'h0096, 14'h0064, 14'h00C8, 1'h0, 1'h1, 1'h0}
    };
    logic               mclk_i, reset_i, son, soff, alarm, mpo, cpo, seq, enc;
    logic               drive, db, il, incr, absd, held;
    logic [MODE_W-1:0]  mode;
    logic [SDLY_W-1:0]  sdly;
    logic [RDLY_W-1:0]  rdly;
    logic [ROUTE_W-1:0] route;
    logic [NOUT-1:0]    other, circ, oexp;
    logic [SPEED_W-1:0] spd, rel, mx;
    int                 mismatches, checks, n;
    ssb_row_t           r;

    ssb_seq #(.TICK_CYCLES(TCK)) u_ssb_seq (
        .mclk_i(mclk_i), .reset_i(reset_i), .servo_on_command_i(son),
        .servo_off_command_i(soff), .servo_alarm_i(alarm), .main_power_off_i(mpo),
        .ctrl_power_off_i(cpo), .motor_speed_i(spd), .max_speed_i(mx),
        .stop_mode_select_i(mode), .brake_sequence_enable_i(seq),
        .stopped_brake_delay_i(sdly), .brake_release_speed_i(rel),
        .running_brake_delay_i(rdly), .brake_output_route_i(route), .other_out_i(other),
        .encoder_abs_mode_i(enc), .motor_drive_o(drive), .dynamic_brake_o(db),
        .brake_interlock_out_o(il), .out_circuit_o(circ), .encoder_incremental_o(incr),
        .abs_detect_enable_o(absd)
    );
    ssb_relay_model u_ssb_relay_model (
        .out_circuit_i(circ), .route_i(route), .brake_held_o(held)
    );

    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    task automatic tick(input int k);
        repeat (k) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask : tick
    // Counts cycles until drive (sel 0) or interlock (sel 1) falls; a hang ends the run
    task automatic wait_low(input logic sel, input int lim, output int cnt);
        cnt = 0;
        while (((sel ? il : drive) !== 1'b0) && cnt < lim) begin
            @(negedge mclk_i);
            cnt++;
        end
        if (cnt >= lim) begin
            chk(16'h1, 16'h0);
            tally_and_finish();
        end
    endtask : wait_low
    // Reset, load settings, bring the servo on and confirm it runs
    task automatic setup(input logic [MODE_W-1:0] m, input logic [SPEED_W-1:0] s,
                         input logic [SDLY_W-1:0] d, input logic q);
        @(posedge mclk_i);
        reset_i <= 1'b1;
        soff <= 1'b0;
        alarm <= 1'b0;
        mode <= m;
        spd <= s;
        sdly <= d;
        seq <= q;
        repeat (4) @(posedge mclk_i);
        reset_i <= 1'b0;
        @(posedge mclk_i);
        son <= 1'b1;
        @(posedge mclk_i);
        son <= 1'b0;
        tick(3);
        chk(16'(drive), 16'h1);
    endtask : setup
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        mismatches = 0;
        checks = 0;
        {reset_i, son, soff, alarm, mpo, cpo, seq, enc} = 8'h80;
        {mode, sdly, route, other} = '0;
        rdly = 7'h0A;
        {spd, rel, mx} = {14'h0000, 14'h0064, 14'h0BB8};
        repeat (10) @(posedge mclk_i);
        @(negedge mclk_i);
        chk(16'({drive, db, il, circ, incr, absd}), 16'h0);
        for (int i = 0; i < 5; i++) begin
            r = ROWS[i];
            @(posedge mclk_i);
            rel <= r.rel;
            mx <= r.mx;
            route <= r.route;
            other <= r.other;
            setup(r.mode, r.spd, 6'h05, 1'b0);
            @(posedge mclk_i);
            soff <= 1'b1;
            tick(2);
            chk(16'(drive), 16'h0);
            chk(16'(db), 16'(r.db));
            tick(2);
            oexp = r.other | ((r.il && r.route != ROUTE_NONE) ? 3'h1 << (r.route - 2'h1) : 3'h0);
            chk(16'(il), 16'(r.il));
            chk(16'(circ), 16'(oexp));
            chk(16'(held), 16'((r.route == ROUTE_NONE) || !oexp[r.route - 2'h1]));
            @(posedge mclk_i);
            spd <= 14'h0000;
            tick(3);
            chk(16'(db), 16'(r.db_end));
            $display("row %0d done", i);
        end
        setup(2'h0, 14'h0000, 6'h02, 1'b0);
        @(posedge mclk_i);
        soff <= 1'b1;
        tick(2);
        chk(16'({drive, il}), 16'h2);
        wait_low(1'b0, 60, n);
        chk(16'(n >= 15 && n <= 21), 16'h1);
        tick(1);
        chk(16'(db), 16'h0);
        $display("stopped delay done");
        setup(2'h0, 14'h0000, 6'h00, 1'b0);
        @(posedge mclk_i);
        soff <= 1'b1;
        tick(1);
        chk(16'(drive ^ il), 16'h0);
        tick(1);
        chk(16'({drive, il}), 16'h0);
        setup(2'h1, 14'h0000, 6'h03, 1'b0);
        @(posedge mclk_i);
        alarm <= 1'b1;
        tick(2);
        chk(16'(drive), 16'h0);
        $display("zero delay and alarm done");
        setup(2'h2, 14'h01F4, 6'h00, 1'b0);
        @(posedge mclk_i);
        alarm <= 1'b1;
        tick(2);
        chk(16'({drive, il}), 16'h1);
        wait_low(1'b1, 200, n);
        chk(16'(n >= 94 && n <= 102), 16'h1);
        $display("running delay done");
        setup(2'h0, 14'h01F4, 6'h32, 1'b1);
        @(posedge mclk_i);
        soff <= 1'b1;
        tick(2);
        chk(16'({drive, il}), 16'h0);
        @(posedge mclk_i);
        son <= 1'b1;
        tick(3);
        chk(16'(drive), 16'h0);
        @(posedge mclk_i);
        son <= 1'b0;
        $display("bypass and refusal done");
        setup(2'h2, 14'h01F4, 6'h00, 1'b0);
        chk(16'({incr, absd}), 16'h1);
        @(posedge mclk_i);
        enc <= 1'b1;
        mpo <= 1'b1;
        cpo <= 1'b1;
        tick(8);
        chk(16'({drive, il}), 16'h0);
        chk(16'(db), 16'h1);
        chk(16'(incr), 16'h0);
        @(posedge mclk_i);
        mpo <= 1'b0;
        cpo <= 1'b0;
        tick(8);
        chk(16'({incr, absd}), 16'h2);
        $display("power and encoder done");
        tally_and_finish();
    end
endmodule : test_servo_stop_brake_sequencer
